// ### src/usart_tx_map.svh
// register offsets, field positions and reset values of the usart transmitter
`ifndef USART_TX_MAP_SVH
`define USART_TX_MAP_SVH

`define UT_OFS_DATA      8'h00
`define UT_OFS_STATUS    8'h04
`define UT_OFS_CONTROL   8'h08
`define UT_OFS_FRAME     8'h0c
`define UT_OFS_BAUD      8'h10

// status register
`define UT_ST_TXC        6
`define UT_ST_EMPTY      5
`define UT_ST_DSPEED     1
// control register
`define UT_CT_TXC_IE     6
`define UT_CT_EMPTY_IE   5
`define UT_CT_TXEN       3
`define UT_CT_NINTH      0
// frame register
`define UT_FR_SYNC       6
`define UT_FR_PAR_EN     5
`define UT_FR_PAR_ODD    4
`define UT_FR_TWO_STOP   3
`define UT_FR_SIZE_HI    2
`define UT_FR_SIZE_LO    0

`define UT_SIZE_9BIT     3'h7
`define UT_FRAME_RESET   8'h06
`define UT_BAUD_RESET    12'h000
`define UT_OVS_NORMAL    4'hf
`define UT_OVS_DOUBLE    4'h7

`endif

// ### src/usart_tx_pkg.sv
// types shared by the usart transmitter
package usart_tx_pkg;
   typedef enum logic [2:0] {
      ST_IDLE   = 3'h0,
      ST_START  = 3'h1,
      ST_DATA   = 3'h3,
      ST_PARITY = 3'h2,
      ST_STOP1  = 3'h6,
      ST_STOP2  = 3'h7
   } tx_state_t;
endpackage

// ### src/usart_bit_timer.sv
// bit period tick from baud divisor, double speed or external transfer clock
`timescale 1ns/1ps
`include "usart_tx_map.svh"
module usart_bit_timer (
   input wire logic clk,
   input wire logic rstn,
   input wire logic run,
   input wire logic sync_mode,
   input wire logic double_speed,
   input wire logic [11:0] baud,
   input wire logic external_transfer_clock,
   output logic tick
);
   logic [11:0] pre_q;
   logic [3:0] sub_q;
   logic xck_q;
   logic sub_end;
   logic async_tick;

   assign sub_end = (pre_q == 12'h000);
   assign async_tick = sub_end &&
      (sub_q == (double_speed ? `UT_OVS_DOUBLE : `UT_OVS_NORMAL));
   // synchronous mode shifts on the falling edge of the transfer clock
   assign tick = run && (sync_mode ? (xck_q && !external_transfer_clock) : async_tick);

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         pre_q <= 12'h000;
         sub_q <= 4'h0;
      end else if (!run) begin
         pre_q <= baud;
         sub_q <= 4'h0;
      end else if (sub_end) begin
         pre_q <= baud;
         sub_q <= async_tick ? 4'h0 : sub_q + 4'h1;
      end else begin
         pre_q <= pre_q - 12'h001;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         xck_q <= 1'b1;
      end else begin
         xck_q <= external_transfer_clock;
      end
   end
endmodule

// ### src/usart_transmitter.sv
// usart transmit half: wishbone registers, one-deep buffer, frame shifter
// Functional notes
// R01: transmit enable takes over the serial output pin as transmitter output.
// R02: synchronous mode takes over the transfer clock pin and times bits from it.
// R03: writing the data register loads the buffer and starts sending the character.
// R04: buffer moves to shifter when idle or right after the last stop bit.
// R05: shifter sends one whole frame timed by baud, double speed or transfer clock.
// R06: unused upper bits of written data are ignored below eight-bit characters.
// R07: nine-bit characters take the ninth bit from the ninth-bit control bit.
// R08: buffer-empty flag is high when empty, low while data waits.
// R09: software writes zero into the buffer-empty flag position.
// R10: buffer-empty interrupt requested while flag set, enabled and globally enabled.
// R11: writing the data register clears the buffer-empty flag.
// R12: buffer-empty handler must write data or disable that interrupt.
// R13: transmit-complete flag set when frame done and buffer holds nothing new.
// R14: transmit-complete clears when its interrupt executes or by writing one.
// R15: transmit-complete interrupt requested once flag sets, enabled and globally enabled.
// R16: with parity enabled, parity bit goes after data, before first stop.
// R17: clearing transmit enable waits until shifter and buffer are drained.
// R18: once effectively disabled, serial output pin returns to port function.
// R19: parity is xor of data bits, inverted for odd parity.
// R20: one or two stop bits as selected, always high.
// R21: line idles high while no transfer runs.
// R22: frame starts with one low start bit, then data least significant first.
`timescale 1ns/1ps
`include "usart_tx_map.svh"
module usart_transmitter (
   input wire logic clk,
   input wire logic rstn,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic global_irq_enable,
   input wire logic tx_complete_irq_taken,
   output logic irq_buffer_empty,
   output logic irq_tx_complete,
   input wire logic port_out,
   input wire logic port_oe,
   output logic txd_o,
   output logic txd_oe,
   input wire logic external_transfer_clock,
   output logic xck_takeover
);
   logic ack_q;
   logic [31:0] rdat_q;
   logic wr;
   logic wr_data;
   logic wr_status;
   logic [7:0] rd_mux;
   logic txc_q;
   logic dspeed_q;
   logic txc_ie_q;
   logic empty_ie_q;
   logic txen_q;
   logic ninth_q;
   logic [7:0] frame_q;
   logic [11:0] baud_q;
   logic eff_en_q;
   logic [8:0] buf_q;
   logic buf_full_q;
   logic [8:0] shift_q;
   logic [3:0] cnt_q;
   logic par_q;
   logic line_q;
   logic txc_prev_q;
   usart_tx_pkg::tx_state_t state_q;
   logic tick;
   logic [2:0] size;
   logic [3:0] nbits;
   logic [8:0] mask;
   logic load;
   logic frame_end;
   logic txc_set;

   assign size = frame_q[`UT_FR_SIZE_HI:`UT_FR_SIZE_LO];
   always_comb begin
      case (size)
         3'h0: nbits = 4'h5;
         3'h1: nbits = 4'h6;
         3'h2: nbits = 4'h7;
         `UT_SIZE_9BIT: nbits = 4'h9;
         default: nbits = 4'h8;
      endcase
   end
   assign mask = 9'h1ff >> (4'h9 - nbits);

   // wishbone classic slave, one wait state
   assign wr = wb_cyc_i && wb_stb_i && wb_we_i && ack_q;
   assign wr_data = wr && wb_sel_i[0] && (wb_adr_i == `UT_OFS_DATA);
   assign wr_status = wr && wb_sel_i[0] && (wb_adr_i == `UT_OFS_STATUS);
   assign wb_ack_o = ack_q;
   assign wb_dat_o = rdat_q;

   always_comb begin
      case (wb_adr_i)
         `UT_OFS_STATUS: begin
            rd_mux = 8'h00;
            rd_mux[`UT_ST_TXC] = txc_q;
            rd_mux[`UT_ST_EMPTY] = !buf_full_q;
            rd_mux[`UT_ST_DSPEED] = dspeed_q;
         end
         `UT_OFS_CONTROL: begin
            rd_mux = 8'h00;
            rd_mux[`UT_CT_TXC_IE] = txc_ie_q;
            rd_mux[`UT_CT_EMPTY_IE] = empty_ie_q;
            rd_mux[`UT_CT_TXEN] = txen_q;
            rd_mux[`UT_CT_NINTH] = ninth_q;
         end
         `UT_OFS_FRAME: rd_mux = frame_q;
         default: rd_mux = 8'h00;
      endcase
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ack_q <= 1'b0;
         rdat_q <= 32'h0000_0000;
      end else begin
         ack_q <= wb_cyc_i && wb_stb_i && !ack_q;
         if (wb_cyc_i && wb_stb_i && !ack_q) begin
            if (wb_adr_i == `UT_OFS_BAUD) begin
               rdat_q <= {20'h00000, baud_q};
            end else begin
               rdat_q <= {24'h000000, rd_mux};
            end
         end
      end
   end

   // control and configuration; empty flag position is read-only
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         dspeed_q <= 1'b0;
         txc_ie_q <= 1'b0;
         empty_ie_q <= 1'b0;
         txen_q <= 1'b0;
         ninth_q <= 1'b0;
         frame_q <= `UT_FRAME_RESET;
         baud_q <= `UT_BAUD_RESET;
      end else if (wr) begin
         if (wb_sel_i[0] && wb_adr_i == `UT_OFS_STATUS) begin
            dspeed_q <= wb_dat_i[`UT_ST_DSPEED];
         end
         if (wb_sel_i[0] && wb_adr_i == `UT_OFS_CONTROL) begin
            txc_ie_q <= wb_dat_i[`UT_CT_TXC_IE];
            empty_ie_q <= wb_dat_i[`UT_CT_EMPTY_IE];
            txen_q <= wb_dat_i[`UT_CT_TXEN];
            ninth_q <= wb_dat_i[`UT_CT_NINTH];
         end
         if (wb_sel_i[0] && wb_adr_i == `UT_OFS_FRAME) begin
            frame_q <= {1'b0, wb_dat_i[6:0]};
         end
         if (wb_adr_i == `UT_OFS_BAUD) begin
            if (wb_sel_i[0]) begin
               baud_q[7:0] <= wb_dat_i[7:0];
            end
            if (wb_sel_i[1]) begin
               baud_q[11:8] <= wb_dat_i[11:8];
            end
         end
      end
   end

   // effective enable: set at once, cleared only when drained
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         eff_en_q <= 1'b0;
      end else if (txen_q) begin
         eff_en_q <= 1'b1;
      end else if (state_q == usart_tx_pkg::ST_IDLE && !buf_full_q && !wr_data) begin
         eff_en_q <= 1'b0; // R17
      end
   end

   assign txd_oe = eff_en_q ? 1'b1 : port_oe; // R01 R18
   assign txd_o = eff_en_q ? line_q : port_out; // R01 R18
   assign xck_takeover = eff_en_q && frame_q[`UT_FR_SYNC]; // R02

   usart_bit_timer u_timer (
      .clk(clk),
      .rstn(rstn),
      .run(state_q != usart_tx_pkg::ST_IDLE),
      .sync_mode(frame_q[`UT_FR_SYNC]),
      .double_speed(dspeed_q),
      .baud(baud_q),
      .external_transfer_clock(external_transfer_clock),
      .tick(tick)
   );

   assign frame_end = tick && ((state_q == usart_tx_pkg::ST_STOP1 &&
      !frame_q[`UT_FR_TWO_STOP]) || state_q == usart_tx_pkg::ST_STOP2);
   assign load = buf_full_q && eff_en_q &&
      (state_q == usart_tx_pkg::ST_IDLE || frame_end); // R04

   // one-deep transmit buffer
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         buf_q <= 9'h000;
         buf_full_q <= 1'b0;
      end else begin
         if (wr_data) begin
            buf_q <= {ninth_q, wb_dat_i[7:0]} & mask; // R03 R06 R07
            buf_full_q <= 1'b1; // R08 R11
         end else if (load) begin
            buf_full_q <= 1'b0; // R08
         end
      end
   end

   // frame shifter; line_q holds the level of the bit being sent
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_q <= usart_tx_pkg::ST_IDLE;
         shift_q <= 9'h000;
         cnt_q <= 4'h0;
         par_q <= 1'b0;
         line_q <= 1'b1;
      end else if (load) begin
         state_q <= usart_tx_pkg::ST_START;
         shift_q <= buf_q;
         cnt_q <= nbits;
         par_q <= (^buf_q) ^ frame_q[`UT_FR_PAR_ODD]; // R19
         line_q <= 1'b0; // R22
      end else if (tick) begin
         case (state_q)
            usart_tx_pkg::ST_START, usart_tx_pkg::ST_DATA: begin
               if (cnt_q != 4'h0) begin
                  state_q <= usart_tx_pkg::ST_DATA;
                  line_q <= shift_q[0]; // R22
                  shift_q <= shift_q >> 1;
                  cnt_q <= cnt_q - 4'h1;
               end else if (frame_q[`UT_FR_PAR_EN]) begin
                  state_q <= usart_tx_pkg::ST_PARITY;
                  line_q <= par_q; // R16
               end else begin
                  state_q <= usart_tx_pkg::ST_STOP1;
                  line_q <= 1'b1; // R20
               end
            end
            usart_tx_pkg::ST_PARITY: begin
               state_q <= usart_tx_pkg::ST_STOP1;
               line_q <= 1'b1; // R20
            end
            usart_tx_pkg::ST_STOP1: begin
               line_q <= 1'b1;
               state_q <= frame_q[`UT_FR_TWO_STOP] ? usart_tx_pkg::ST_STOP2
                  : usart_tx_pkg::ST_IDLE; // R20
            end
            usart_tx_pkg::ST_STOP2: begin
               line_q <= 1'b1;
               state_q <= usart_tx_pkg::ST_IDLE;
            end
            default: begin
               state_q <= usart_tx_pkg::ST_IDLE;
               line_q <= 1'b1; // R21
            end
         endcase
      end
   end

   // transmit complete: set wins over both clears
   assign txc_set = frame_end && !buf_full_q; // R13
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         txc_q <= 1'b0;
         txc_prev_q <= 1'b0;
      end else begin
         txc_prev_q <= txc_q;
         if (txc_set) begin
            txc_q <= 1'b1; // R13
         end else if (tx_complete_irq_taken ||
                      (wr_status && wb_dat_i[`UT_ST_TXC])) begin
            txc_q <= 1'b0; // R14
         end
      end
   end

   assign irq_buffer_empty = empty_ie_q && !buf_full_q && global_irq_enable; // R10
   assign irq_tx_complete = txc_ie_q && txc_q && global_irq_enable; // R15

   sequence write_s;
      wr_data;
   endsequence
   sequence stop_end_s;
      frame_end && !buf_full_q;
   endsequence

   idle_line_high_a: assert property (@(posedge clk) disable iff (!rstn) // R21
      state_q == usart_tx_pkg::ST_IDLE |-> line_q)
      else $error("line not high while idle");
   start_bit_low_a: assert property (@(posedge clk) disable iff (!rstn) // R22
      state_q == usart_tx_pkg::ST_START |-> !line_q)
      else $error("start bit not low");
   stop_bits_high_a: assert property (@(posedge clk) disable iff (!rstn) // R20
      (state_q == usart_tx_pkg::ST_STOP1 || state_q == usart_tx_pkg::ST_STOP2) |-> line_q)
      else $error("stop bit not high");
   parity_value_a: assert property (@(posedge clk) disable iff (!rstn) // R16
      state_q == usart_tx_pkg::ST_PARITY |-> line_q == par_q && frame_q[`UT_FR_PAR_EN])
      else $error("parity bit wrong");
   write_fills_a: assert property (@(posedge clk) disable iff (!rstn) // R11
      write_s |=> buf_full_q && !irq_buffer_empty)
      else $error("data write did not fill buffer");
   idle_load_a: assert property (@(posedge clk) disable iff (!rstn) // R04
      state_q == usart_tx_pkg::ST_IDLE && buf_full_q && eff_en_q && !wr_data
      |=> state_q == usart_tx_pkg::ST_START && !buf_full_q)
      else $error("idle shifter did not load buffer");
   txc_sets_a: assert property (@(posedge clk) disable iff (!rstn) // R13
      stop_end_s |=> txc_q ##0 state_q == usart_tx_pkg::ST_IDLE)
      else $error("transmit complete not set at frame end");
   txc_clears_a: assert property (@(posedge clk) disable iff (!rstn) // R14
      txc_q && tx_complete_irq_taken && !txc_set |=> !txc_q)
      else $error("transmit complete not cleared");
   disable_defer_a: assert property (@(posedge clk) disable iff (!rstn) // R17
      eff_en_q && (buf_full_q || state_q != usart_tx_pkg::ST_IDLE) |=> eff_en_q && txd_oe)
      else $error("transmitter released pin early");
   txc_irq_a: assert property (@(posedge clk) disable iff (!rstn) // R15
      txc_q && !txc_prev_q && txc_ie_q && global_irq_enable |-> irq_tx_complete)
      else $error("transmit complete interrupt missing");
endmodule

// ### tb/serial_rx_model.sv
// behavioural serial receiver watching the transmit line
`timescale 1ns/1ps
module serial_rx_model (
   input wire logic clk,
   input wire logic line,
   input wire logic [7:0] bit_cycles,
   input wire logic [3:0] nbits,
   input wire logic par_en,
   input wire logic par_odd,
   input wire logic two_stop,
   output logic [8:0] rx_data,
   output logic rx_ok,
   output logic [7:0] rx_count
);
   logic prev;
   logic par;
   initial begin
      rx_data = 9'h000;
      rx_ok = 1'b0;
      rx_count = 8'h00;
      prev = 1'b1;
      forever begin
         @(posedge clk);
         if (prev === 1'b1 && line === 1'b0) begin
            // sample mid start bit, then mid each later bit
            repeat (bit_cycles / 2) @(posedge clk);
            rx_ok = (line === 1'b0);
            rx_data = 9'h000;
            par = par_odd;
            for (int i = 0; i < nbits; i++) begin
               repeat (bit_cycles) @(posedge clk);
               rx_data[i] = line;
               par = par ^ line;
            end
            if (par_en) begin
               repeat (bit_cycles) @(posedge clk);
               rx_ok = rx_ok && (line === par);
            end
            repeat (bit_cycles) @(posedge clk);
            rx_ok = rx_ok && (line === 1'b1);
            if (two_stop) begin
               repeat (bit_cycles) @(posedge clk);
               rx_ok = rx_ok && (line === 1'b1);
            end
            rx_count = rx_count + 8'h01;
         end
         prev = line;
      end
   end
endmodule

// ### tb/test_usart_transmitter.sv
// self-checking bench for the usart transmitter
`timescale 1ns/1ps
`include "usart_tx_map.svh"
module test_usart_transmitter;
   typedef struct packed {
      logic [2:0] size;
      logic par_en;
      logic odd;
      logic two;
      logic ninth;
      logic [7:0] data;
   } frame_case_t;
   localparam logic [31:0] txen_w = 32'h1 << `UT_CT_TXEN;
   logic clk, rstn, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, line, rx_ok;
   logic [7:0] wb_adr_i, m_bits, rx_count, base;
   logic [31:0] wb_dat_i, wb_dat_o, rdat, st_keep;
   logic global_irq_enable, tx_complete_irq_taken, irq_buffer_empty, irq_tx_complete;
   logic port_out, port_oe, txd_o, txd_oe, xck_takeover, m_par_en, m_odd, m_two;
   logic [3:0] m_nbits;
   logic [8:0] rx_data;
   int n_errors, total_checks, cycles;
   frame_case_t cases [6];
   // pull-up on the wire while nobody drives it
   assign line = txd_oe ? txd_o : 1'b1;
   usart_transmitter dut_u (.clk(clk), .rstn(rstn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hf), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .global_irq_enable(global_irq_enable),
      .tx_complete_irq_taken(tx_complete_irq_taken), .irq_buffer_empty(irq_buffer_empty),
      .irq_tx_complete(irq_tx_complete), .port_out(port_out), .port_oe(port_oe),
      .txd_o(txd_o), .txd_oe(txd_oe), .external_transfer_clock(1'b0),
      .xck_takeover(xck_takeover));
   serial_rx_model rx_u (.clk(clk), .line(line), .bit_cycles(m_bits), .nbits(m_nbits),
      .par_en(m_par_en), .par_odd(m_odd), .two_stop(m_two), .rx_data(rx_data),
      .rx_ok(rx_ok), .rx_count(rx_count));
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   task automatic summarize();
      if (n_errors == 0 && total_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         n_errors++;
         summarize();
      end
   end
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d);
      int n;
      n = 0;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_dat_i <= d;
      @(posedge clk);
      while (wb_ack_o !== 1'b1 && n < 100) begin
         @(posedge clk);
         n++;
      end
      chk("wb_ack_o", 32'h1, {31'h0, wb_ack_o});
      rdat = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge clk);
   endtask
   task automatic wait_rx(input logic [7:0] target);
      int n;
      n = 0;
      while (rx_count !== target && n < 1000) begin
         @(posedge clk);
         n++;
      end
      chk("rx_count", {24'h0, target}, {24'h0, rx_count});
   endtask
   task automatic poll_txc();
      int n;
      n = 0;
      rdat = 32'h0;
      while (rdat[`UT_ST_TXC] !== 1'b1 && n < 200) begin
         wb(1'b0, `UT_OFS_STATUS, 32'h0);
         n++;
      end
      chk("txc_set", 32'h1, {31'h0, rdat[`UT_ST_TXC]});
      chk("empty_flag", 32'h1, {31'h0, rdat[`UT_ST_EMPTY]});
   endtask
   task automatic clr_txc();
      wb(1'b1, `UT_OFS_STATUS, st_keep | (32'h1 << `UT_ST_TXC));
      wb(1'b0, `UT_OFS_STATUS, 32'h0);
      chk("txc_clear", 32'h0, {31'h0, rdat[`UT_ST_TXC]});
   endtask
   task automatic send_frame(input frame_case_t c);
      int nb;
      logic [8:0] exp;
      logic [7:0] cnt0;
      nb = (c.size == `UT_SIZE_9BIT) ? 9 : c.size + 5;
      exp = {c.ninth, c.data} & 9'((1 << nb) - 1);
      m_nbits <= 4'(nb);
      m_par_en <= c.par_en;
      m_odd <= c.odd;
      m_two <= c.two;
      wb(1'b1, `UT_OFS_FRAME, {25'h0, 1'b0, c.par_en, c.odd, c.two, c.size});
      wb(1'b1, `UT_OFS_CONTROL, txen_w | {31'h0, c.ninth});
      cnt0 = rx_count;
      wb(1'b1, `UT_OFS_DATA, {24'h0, c.data});
      wait_rx(cnt0 + 8'h01);
      chk("rx_data", {23'h0, exp}, {23'h0, rx_data});
      chk("rx_frame_ok", 32'h1, {31'h0, rx_ok});
      poll_txc();
      clr_txc();
   endtask
   initial begin
      {rstn, wb_cyc_i, wb_stb_i, wb_we_i, global_irq_enable, tx_complete_irq_taken} = 6'h00;
      {port_out, port_oe, m_par_en, m_odd, m_two} = 5'h00;
      wb_adr_i = 8'h00;
      wb_dat_i = 32'h0;
      m_bits = 8'h10;
      m_nbits = 4'h8;
      st_keep = 32'h0;
      cases[0] = '{3'h0, 1'b0, 1'b0, 1'b0, 1'b0, 8'hff};
      cases[1] = '{3'h1, 1'b1, 1'b0, 1'b0, 1'b0, 8'hd6};
      cases[2] = '{3'h2, 1'b1, 1'b1, 1'b1, 1'b0, 8'h35};
      cases[3] = '{3'h3, 1'b0, 1'b0, 1'b1, 1'b0, 8'ha5};
      cases[4] = '{3'h7, 1'b1, 1'b1, 1'b0, 1'b1, 8'h3c};
      cases[5] = '{3'h7, 1'b0, 1'b0, 1'b0, 1'b0, 8'hc3};
      repeat (16) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      chk("txd_o_off", {31'h0, port_out}, {31'h0, txd_o});
      chk("txd_oe_off", 32'h0, {31'h0, txd_oe});
      chk("xck_off", 32'h0, {31'h0, xck_takeover});
      wb(1'b0, `UT_OFS_FRAME, 32'h0);
      chk("frame_reset", {24'h0, `UT_FRAME_RESET}, rdat);
      wb(1'b0, `UT_OFS_STATUS, 32'h0);
      chk("status_reset", 32'h1 << `UT_ST_EMPTY, rdat);
      wb(1'b0, 8'h20, 32'h0);
      chk("unmapped", 32'h0, rdat);
      wb(1'b1, `UT_OFS_CONTROL, txen_w);
      // effective enable follows the control bit one clock later
      @(posedge clk);
      chk("txd_oe_on", 32'h1, {31'h0, txd_oe});
      chk("txd_idle", 32'h1, {31'h0, txd_o});
      wb(1'b1, `UT_OFS_FRAME, (32'h1 << `UT_FR_SYNC) | 32'h6);
      chk("xck_on", 32'h1, {31'h0, xck_takeover});
      for (int i = 0; i < 6; i++) begin
         send_frame(cases[i]);
      end
      st_keep = 32'h1 << `UT_ST_DSPEED;
      m_bits <= 8'h08;
      wb(1'b1, `UT_OFS_STATUS, st_keep);
      send_frame(cases[3]);
      st_keep = 32'h0;
      m_bits <= 8'h10;
      wb(1'b1, `UT_OFS_STATUS, 32'h0);
      global_irq_enable <= 1'b1;
      wb(1'b1, `UT_OFS_CONTROL, txen_w | (32'h1 << `UT_CT_TXC_IE) | (32'h1 << `UT_CT_EMPTY_IE));
      chk("irq_empty_on", 32'h1, {31'h0, irq_buffer_empty});
      base = rx_count;
      wb(1'b1, `UT_OFS_DATA, 32'h5a);
      wb(1'b1, `UT_OFS_DATA, 32'ha7);
      wb(1'b0, `UT_OFS_STATUS, 32'h0);
      chk("empty_full", 32'h0, {31'h0, rdat[`UT_ST_EMPTY]});
      chk("irq_empty_full", 32'h0, {31'h0, irq_buffer_empty});
      wait_rx(base + 8'h01);
      chk("rx_first", 32'h5a, {23'h0, rx_data});
      wait_rx(base + 8'h02);
      chk("rx_second", 32'ha7, {23'h0, rx_data});
      poll_txc();
      chk("irq_txc_on", 32'h1, {31'h0, irq_tx_complete});
      chk("irq_empty_idle", 32'h1, {31'h0, irq_buffer_empty});
      global_irq_enable <= 1'b0;
      @(posedge clk);
      chk("irq_txc_gl", 32'h0, {31'h0, irq_tx_complete});
      chk("irq_empty_gl", 32'h0, {31'h0, irq_buffer_empty});
      global_irq_enable <= 1'b1;
      tx_complete_irq_taken <= 1'b1;
      @(posedge clk);
      tx_complete_irq_taken <= 1'b0;
      wb(1'b0, `UT_OFS_STATUS, 32'h0);
      chk("txc_taken", 32'h0, {31'h0, rdat[`UT_ST_TXC]});
      chk("irq_txc_off", 32'h0, {31'h0, irq_tx_complete});
      base = rx_count;
      wb(1'b1, `UT_OFS_DATA, 32'h81);
      wb(1'b1, `UT_OFS_DATA, 32'h7e);
      wb(1'b1, `UT_OFS_CONTROL, 32'h0);
      chk("oe_deferred", 32'h1, {31'h0, txd_oe});
      wait_rx(base + 8'h02);
      chk("rx_last", 32'h7e, {23'h0, rx_data});
      poll_txc();
      wb(1'b0, `UT_OFS_STATUS, 32'h0);
      chk("oe_released", {31'h0, port_oe}, {31'h0, txd_oe});
      chk("txd_released", {31'h0, port_out}, {31'h0, txd_o});
      summarize();
   end
endmodule
